/* File: verilog/ltec_exposure_ctrl.v */
/*
 * ltec_exposure_ctrl: line trigger exposure control.
 * assumes one 250 MHz clock, synchronous active-low reset, and an
 * asynchronous trigger input from the frame grabber.
 */
// Local design decisions: the address-and-strobe port and the register offsets.
// Summary of operation
// - one line acquired per trigger period; line rate follows trigger.
// - trigger spacing may be irregular; no fixed period assumed.
// - edge, level, programmed modes; each line starts on rising edge.
// - edge mode exposes the full period, rising edge to rising edge.
// - edge mode reads out on rising edge, ignores falling edge.
// - level mode exposure runs from falling edge to next rising edge.
// - level mode integrates while trigger low, reads out on rise.
// - programmed mode: rising edge starts exposure of set length.
// - programmed mode reads out when the set exposure expires.
// - programmed mode ignores falling edge and trigger pulse width.
// - exposure length for programmed mode is a software setting.
// - enhanced raw mode line rate must stay at or below 137 kHz.
// - free-run mode makes its own internal control signal.
// - exposure starts 1.21 us (2.51 us edge) after relevant edge.
// - over-long programmed exposure completes; triggers ignored.
`timescale 1ns/1ps
`include "ltec_map.vh"

module ltec_exposure_ctrl
(
    // clock and reset
    input wire clock,
    input wire rst_b,
    // external line trigger
    input wire ext_line_trigger,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // sensor control
    output reg line_start,
    output reg integrate,
    output reg readout,
    output reg raw_rate_violation
);

// ****************************************************
// register offsets
// ****************************************************
localparam [3:0] ADDR_MODE = 4'h0;
localparam [3:0] ADDR_EXP = 4'h4;
localparam [3:0] ADDR_PER = 4'h8;
localparam [3:0] ADDR_STAT = 4'hC;

// ****************************************************
// states, one-hot
// ****************************************************
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_DELAY = 5'h02;
localparam [4:0] ST_EXPOSE = 5'h04;
localparam [4:0] ST_WAIT_FALL = 5'h08;
localparam [4:0] ST_PROG = 5'h10;

// ****************************************************
// configuration registers
// ****************************************************
reg [`LTEC_MODE_W-1:0] mode;
reg raw_enable;
reg line_a_delayed;
reg [`LTEC_CNT_W-1:0] exp_time;
reg [`LTEC_CNT_W-1:0] line_period;
reg [31:0] line_count;

always @(posedge clock)
begin
    if (!rst_b)
    begin
        mode <= `LTEC_MODE_EDGE;
        raw_enable <= 1'b0;
        line_a_delayed <= 1'b0;
        exp_time <= `LTEC_EXP_RST;
        line_period <= `LTEC_PER_RST;
    end
    else if (reg_wr)
    begin
        case (reg_addr)
            ADDR_MODE:
            begin
                mode <= reg_wdata[1:0];
                raw_enable <= reg_wdata[4];
                line_a_delayed <= reg_wdata[8];
            end
            ADDR_EXP: exp_time <= reg_wdata;
            ADDR_PER: line_period <= reg_wdata;
            default: ;
        endcase
    end
end

// ****************************************************
// trigger synchroniser and free-run source
// ****************************************************
reg trig_meta;
reg trig_sync;
reg trig_last;
reg free_sig;
reg [`LTEC_CNT_W-1:0] free_cnt;
wire free_run = (mode == `LTEC_MODE_FREE);
wire ctrl_sig = free_run ? free_sig : trig_sync;
reg ctrl_last;
wire rise = ctrl_sig & ~ctrl_last;
wire fall = ~ctrl_sig & ctrl_last;

always @(posedge clock)
begin
    if (!rst_b)
    begin
        trig_meta <= 1'b0;
        trig_sync <= 1'b0;
        trig_last <= 1'b0;
        ctrl_last <= 1'b0;
    end
    else
    begin
        trig_meta <= ext_line_trigger;
        trig_sync <= trig_meta;
        trig_last <= trig_sync;
        ctrl_last <= ctrl_sig;
    end
end

// internal control: high for the first half of the line period
always @(posedge clock)
begin
    if (!rst_b || !free_run)
    begin
        free_cnt <= {`LTEC_CNT_W{1'b0}};
        free_sig <= 1'b0;
    end
    else if (free_cnt + {{(`LTEC_CNT_W-1){1'b0}}, 1'b1} >= line_period)
    begin
        free_cnt <= {`LTEC_CNT_W{1'b0}};
        free_sig <= 1'b1;
    end
    else
    begin
        free_cnt <= free_cnt + {{(`LTEC_CNT_W-1){1'b0}}, 1'b1};
        free_sig <= (free_cnt < (line_period >> 1));
    end
end

// ****************************************************
// exposure state machine
// ****************************************************
reg [4:0] state;
reg [4:0] next_state;
reg tmr_load;
reg [`LTEC_CNT_W-1:0] tmr_count;
wire tmr_done;
wire eff_edge = (mode == `LTEC_MODE_EDGE) || free_run;

ltec_delay_timer u_timer
(
    .clock(clock),
    .rst_b(rst_b),
    .load(tmr_load),
    .count(tmr_count),
    .cancel(1'b0),
    .busy(),
    .done(tmr_done)
);

always @*
begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_count = `LTEC_DLY_SHORT_CYC;
    case (state)
        ST_IDLE:
        begin
            if (rise)
            begin
                tmr_load = 1'b1;
                if (eff_edge)
                begin
                    tmr_count = `LTEC_DLY_EDGE_CYC;
                    next_state = ST_DELAY;
                end
                else if (mode == `LTEC_MODE_LEVEL)
                begin
                    tmr_load = 1'b0;
                    next_state = ST_WAIT_FALL;
                end
                else
                begin
                    next_state = ST_DELAY;
                end
            end
        end
        ST_WAIT_FALL:
        begin
            if (fall)
            begin
                tmr_load = 1'b1;
                next_state = ST_DELAY;
            end
        end
        ST_DELAY:
        begin
            if (tmr_done)
            begin
                if (mode == `LTEC_MODE_PROG)
                begin
                    tmr_load = 1'b1;
                    tmr_count = exp_time;
                    next_state = ST_PROG;
                end
                else
                begin
                    next_state = ST_EXPOSE;
                end
            end
        end
        ST_EXPOSE:
        begin
            // edge: close on next rise; level: also close on rise
            if (rise)
            begin
                tmr_load = 1'b1;
                if (eff_edge)
                begin
                    tmr_count = `LTEC_DLY_EDGE_CYC;
                    next_state = ST_DELAY;
                end
                else
                begin
                    tmr_load = 1'b0;
                    next_state = ST_WAIT_FALL;
                end
            end
        end
        ST_PROG:
        begin
            if (tmr_done)
            begin
                next_state = ST_IDLE;
            end
        end
        default: next_state = ST_IDLE;
    endcase
end

always @(posedge clock)
begin
    if (!rst_b)
    begin
        state <= ST_IDLE;
    end
    else
    begin
        state <= next_state;
    end
end

// ****************************************************
// sensor outputs
// ****************************************************
wire readout_now = (rise && state == ST_EXPOSE) ||
    (state == ST_PROG && tmr_done);
wire ignored = rise && (state == ST_PROG ||
    state == ST_DELAY);

always @(posedge clock)
begin
    if (!rst_b)
    begin
        line_start <= 1'b0;
        integrate <= 1'b0;
        readout <= 1'b0;
        line_count <= 32'h00000000;
    end
    else
    begin
        line_start <= rise && !ignored;
        readout <= readout_now;
        // programmed exposure counted from the second cycle in ST_PROG
        integrate <= (next_state == ST_EXPOSE) ||
            (state == ST_PROG && next_state == ST_PROG);
        if (readout_now)
        begin
            line_count <= line_count + 32'h00000001;
        end
    end
end

// ****************************************************
// enhanced raw line rate watch
// ****************************************************
reg [`LTEC_CNT_W-1:0] period_cnt;

always @(posedge clock)
begin
    if (!rst_b)
    begin
        // saturated: first rise after reset has no period to judge
        period_cnt <= {`LTEC_CNT_W{1'b1}};
        raw_rate_violation <= 1'b0;
    end
    else if (rise)
    begin
        period_cnt <= {`LTEC_CNT_W{1'b0}};
        if (raw_enable && !free_run &&
            period_cnt < `LTEC_RAW_MIN_PERIOD_CYC - 1)
        begin
            raw_rate_violation <= 1'b1;
        end
    end
    else
    begin
        if (reg_wr && reg_addr == ADDR_STAT && reg_wdata[0])
        begin
            raw_rate_violation <= 1'b0;
        end
        if (period_cnt != {`LTEC_CNT_W{1'b1}})
        begin
            period_cnt <= period_cnt + {{(`LTEC_CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

// ****************************************************
// register read port
// ****************************************************
always @(posedge clock)
begin
    if (!rst_b)
    begin
        reg_rdata <= 32'h00000000;
    end
    else if (reg_rd)
    begin
        case (reg_addr)
            ADDR_MODE: reg_rdata <= {23'h000000, line_a_delayed,
                3'h0, raw_enable, 2'h0, mode};
            ADDR_EXP: reg_rdata <= exp_time;
            ADDR_PER: reg_rdata <= line_period;
            ADDR_STAT: reg_rdata <= {trig_last, integrate,
                raw_rate_violation, state, line_count[23:0]};
            default: reg_rdata <= 32'h00000000;
        endcase
    end
    else
    begin
        reg_rdata <= 32'h00000000;
    end
end

endmodule // ltec_exposure_ctrl

/* File: include/ltec_map.vh */
/*
 * constants for the line trigger exposure control block:
 * mode encodings, timing figures and derived cycle counts.
 * assumes a 250 MHz core clock (4 ns period).
 */
`ifndef LTEC_MAP_VH
`define LTEC_MAP_VH

// ****************************************************
// clock
// ****************************************************
`define LTEC_CLK_PS 4000

// ****************************************************
// exposure modes
// ****************************************************
`define LTEC_MODE_W 2
`define LTEC_MODE_EDGE 2'h0
`define LTEC_MODE_LEVEL 2'h1
`define LTEC_MODE_PROG 2'h2
`define LTEC_MODE_FREE 2'h3

// ****************************************************
// exposure start delays, in ps, and cycle counts
// ****************************************************
`define LTEC_DLY_SHORT_PS 1210000
`define LTEC_DLY_EDGE_PS 2510000
`define LTEC_DLY_SHORT_CYC (`LTEC_DLY_SHORT_PS / `LTEC_CLK_PS)
`define LTEC_DLY_EDGE_CYC (`LTEC_DLY_EDGE_PS / `LTEC_CLK_PS)

// ****************************************************
// trigger pulse minima (far side), in ps and cycles
// ****************************************************
`define LTEC_HIGH_LEVEL_PS 1300000
`define LTEC_HIGH_EDGE_PS 100000
`define LTEC_LOW_MIN_PS 2000000
`define LTEC_HIGH_LEVEL_CYC \
    ((`LTEC_HIGH_LEVEL_PS + `LTEC_CLK_PS - 1) / `LTEC_CLK_PS)
`define LTEC_LOW_MIN_CYC \
    ((`LTEC_LOW_MIN_PS + `LTEC_CLK_PS - 1) / `LTEC_CLK_PS)

// ****************************************************
// enhanced raw mode line rate ceiling, in Hz
// ****************************************************
`define LTEC_RAW_MAX_HZ 137000
`define LTEC_RAW_MIN_PERIOD_CYC \
    ((250000000 + `LTEC_RAW_MAX_HZ - 1) / `LTEC_RAW_MAX_HZ)

// ****************************************************
// counter width and defaults
// ****************************************************
`define LTEC_CNT_W 32
`define LTEC_EXP_RST 32'h00000FA0
`define LTEC_PER_RST 32'h00002710

`endif

/* File: verilog/ltec_delay_timer.v */
/*
 * ltec_delay_timer: loadable down-counter, one-cycle done pulse.
 * assumes load and count come from the same clock domain; a zero count loads as one.
 */
`timescale 1ns/1ps
`include "ltec_map.vh"

module ltec_delay_timer
(
    // clock and reset
    input wire clock,
    input wire rst_b,
    // control
    input wire load,
    input wire [`LTEC_CNT_W-1:0] count,
    input wire cancel,
    // status
    output reg busy,
    output reg done
);

reg [`LTEC_CNT_W-1:0] remain;

always @(posedge clock)
begin
    if (!rst_b)
    begin
        remain <= {`LTEC_CNT_W{1'b0}};
        busy <= 1'b0;
        done <= 1'b0;
    end
    else if (cancel)
    begin
        busy <= 1'b0;
        done <= 1'b0;
    end
    else if (load)
    begin
        remain <= (count == {`LTEC_CNT_W{1'b0}}) ?
            {{(`LTEC_CNT_W-1){1'b0}}, 1'b1} : count;
        busy <= 1'b1;
        done <= 1'b0;
    end
    else if (busy)
    begin
        remain <= remain - {{(`LTEC_CNT_W-1){1'b0}}, 1'b1};
        done <= (remain == {{(`LTEC_CNT_W-1){1'b0}}, 1'b1});
        busy <= (remain != {{(`LTEC_CNT_W-1){1'b0}}, 1'b1});
    end
    else
    begin
        done <= 1'b0;
    end
end

endmodule // ltec_delay_timer

/* File: bench/ltec_monitor.sv */
/* checker for the exposure control ports.
   assumes mode at 0x0, exposure at 0x4 and sync reset low. */
`timescale 1ns/1ps
module ltec_monitor
(
    // clock and reset
    input wire clock,
    input wire rst_b,
    // inputs
    input wire ext_line_trigger,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    // outputs
    input wire [31:0] reg_rdata,
    input wire line_start,
    input wire integrate,
    input wire readout,
    input wire raw_rate_violation
);
    reg [1:0] mode;
    reg [31:0] exp_cyc;
    reg [31:0] run;
    reg [31:0] since;
    reg trig_d;
    wire clr = reg_wr && reg_addr == 4'hC && reg_wdata[0];
    // ****
    // shadow of mode and exposure, delay and run counters
    // ****
    always @(posedge clock)
    begin
        trig_d <= ext_line_trigger;
        run <= integrate ? run + 32'h1 : 32'h0;
        since <= since + 32'h1;
        if (mode == 2'h1 && trig_d && !ext_line_trigger)
            since <= 32'h0;
        if (mode != 2'h1 && line_start)
            since <= 32'h0;
        if (reg_wr && reg_addr == 4'h0)
            mode <= reg_wdata[1:0];
        if (reg_wr && reg_addr == 4'h4)
            exp_cyc <= reg_wdata;
        if (!rst_b)
        begin
            mode <= 2'h0;
            exp_cyc <= 32'h00000FA0;
            run <= 32'h0;
            since <= 32'h0;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_readout_near;
        ##[0:1] readout;
    endsequence
    a_start_on_rise: assert property (
        (mode != 2'h3 && line_start) |->
        $past(ext_line_trigger, 2) && !$past(ext_line_trigger, 8))
        else $error("line start without trigger rise");
    a_rise_readout: assert property (
        (mode < 2'h2 && readout) |-> $past(ext_line_trigger, 2))
        else $error("readout off rising edge");
    a_level_low_only: assert property (
        (mode == 2'h1 && integrate) |-> !$past(ext_line_trigger, 6))
        else $error("level exposure while high");
    a_level_start_gap: assert property (
        (mode == 2'h1 && $rose(integrate)) |->
        since >= 300 && since <= 310) else $error("level start delay");
    a_edge_start_gap: assert property (
        (mode == 2'h0 && $rose(integrate)) |->
        since >= 618 && since <= 632) else $error("edge start delay");
    a_prog_start_gap: assert property (
        (mode == 2'h2 && $rose(integrate)) |->
        since >= 296 && since <= 306) else $error("prog start delay");
    a_prog_exp_length: assert property (
        (mode == 2'h2 && $fell(integrate)) |->
        run == (exp_cyc == 32'h0 ? 32'h1 : exp_cyc))
        else $error("prog exposure length");
    a_prog_readout_end: assert property (
        (mode == 2'h2 && $fell(integrate)) |->
        $past(readout) or s_readout_near) else $error("prog readout late");
    a_prog_no_retrig: assert property (
        (mode == 2'h2 && integrate) |-> !line_start)
        else $error("trigger taken during exposure");
    a_raw_flag_sticky: assert property (
        (raw_rate_violation && !clr) |=> raw_rate_violation)
        else $error("raw flag dropped");
endmodule // ltec_monitor
bind ltec_exposure_ctrl ltec_monitor u_mon (.clock, .rst_b,
    .ext_line_trigger, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .line_start, .integrate, .readout, .raw_rate_violation);

/* File: bench/ltec_trigger_source.sv */
/* frame grabber model driving the line trigger.
   assumes the caller sets widths; 25-cycle high and 500-cycle low minima are enforced here. */
`timescale 1ns/1ps
module ltec_trigger_source
(
    // clock
    input wire clock,
    // trigger toward the camera
    output reg ext_line_trigger
);
    initial ext_line_trigger = 1'b0;
    // one pulse, spacing free per call
    task pulse(input integer hi, input integer lo);
    begin
        @(posedge clock);
        ext_line_trigger <= 1'b1;
        repeat (hi < 25 ? 25 : hi) @(posedge clock);
        ext_line_trigger <= 1'b0;
        repeat (lo < 500 ? 500 : lo) @(posedge clock);
    end
    endtask
endmodule // ltec_trigger_source

/* File: bench/line_trigger_exposure_control_bench.sv */
/* self-checking bench for the exposure control block.
   assumes the trigger model and checker files compile first. */
`timescale 1ns/1ps
module line_trigger_exposure_control_bench;
    reg clock = 1'b0;
    reg rst_b = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    wire [31:0] reg_rdata;
    wire ext_line_trigger;
    wire line_start;
    wire integrate;
    wire readout;
    wire raw_rate_violation;
    integer n_mismatch = 0;
    integer compares = 0;
    integer n_line = 0;
    integer n_rdo = 0;
    integer base_rdo = 0;
    integer run = 0;
    integer last_run = 0;
    integer cyc = 0;
    integer base;
    reg [31:0] d;
    ltec_exposure_ctrl dut (.clock, .rst_b, .ext_line_trigger, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .line_start, .integrate,
        .readout, .raw_rate_violation);
    ltec_trigger_source grab (.clock, .ext_line_trigger);
    initial forever #2 clock = ~clock;
    // ****
    // line count, exposure run length, timeout
    // ****
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (line_start)
            n_line <= n_line + 1;
        if (readout)
            n_rdo <= n_rdo + 1;
        if (integrate)
            run <= run + 1;
        else
        begin
            if (run != 0)
                last_run <= run;
            run <= 0;
        end
        if (cyc == 40000)
        begin
            n_mismatch = n_mismatch + 1;
            final_report;
        end
    end
    task final_report;
    begin
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            n_mismatch = n_mismatch + 1;
        end
    end
    endtask
    task wr(input [3:0] a, input [31:0] v);
    begin
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    end
    endtask
    task rd(input [3:0] a, output [31:0] v);
    begin
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    end
    endtask
    task reset_dut;
    begin
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        base = n_line;
        base_rdo = n_rdo;
    end
    endtask
    // ****
    // scenarios
    // ****
    task t_regs;
    begin
        rd(4'h0, d);
        chk("mode reset", 32'h0, d);
        rd(4'h4, d);
        chk("exposure reset", 32'h00000FA0, d);
        rd(4'h8, d);
        chk("period reset", 32'h00002710, d);
        wr(4'h2, 32'hFFFFFFFF);
        rd(4'h2, d);
        chk("unmapped", 32'h0, d);
        wr(4'h4, 32'h00000123);
        rd(4'h4, d);
        chk("exposure", 32'h00000123, d);
    end
    endtask
    task t_edge;
    begin
        reset_dut;
        grab.pulse(30, 1000);
        grab.pulse(40, 700);
        grab.pulse(30, 1500);
        chk("edge lines", 32'h3, n_line - base);
        chk("edge run", 32'h1,
            {31'h0, last_run >= 107 && last_run <= 119});
        chk("edge readouts", 32'h2, n_rdo - base_rdo);
        chk("raw idle", 32'h0, {31'h0, raw_rate_violation});
    end
    endtask
    task t_level;
    begin
        reset_dut;
        wr(4'h0, 32'h00000001);
        grab.pulse(400, 800);
        grab.pulse(400, 900);
        grab.pulse(400, 600);
        chk("level lines", 32'h3, n_line - base);
        chk("level run", 32'h1,
            {31'h0, last_run >= 592 && last_run <= 604});
        chk("level readouts", 32'h2, n_rdo - base_rdo);
    end
    endtask
    task t_prog;
    begin
        reset_dut;
        wr(4'h0, 32'h00000102);
        wr(4'h4, 32'h00000064);
        grab.pulse(30, 600);
        chk("prog run", 32'h64, last_run);
        grab.pulse(300, 600);
        chk("prog wide", 32'h64, last_run);
        wr(4'h4, 32'h000005DC);
        base = n_line;
        repeat (3) grab.pulse(30, 600);
        chk("prog long lines", 32'h1, n_line - base);
        chk("prog long run", 32'h5DC, last_run);
        chk("prog readouts", 32'h3, n_rdo - base_rdo);
    end
    endtask
    task t_raw;
    begin
        reset_dut;
        wr(4'h0, 32'h00000010);
        repeat (2) grab.pulse(30, 1000);
        chk("raw flag", 32'h1, {31'h0, raw_rate_violation});
        rd(4'hC, d);
        chk("raw status", 32'h1, {31'h0, d[29]});
        wr(4'hC, 32'h00000001);
        #1 chk("raw cleared", 32'h0, {31'h0, raw_rate_violation});
    end
    endtask
    task t_free;
    begin
        reset_dut;
        wr(4'h8, 32'h000003E8);
        wr(4'h0, 32'h00000003);
        base = n_line;
        repeat (3500) @(posedge clock);
        chk("free lines", 32'h1,
            {31'h0, n_line - base >= 3 && n_line - base <= 4});
    end
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_regs;
        t_edge;
        t_level;
        t_prog;
        t_raw;
        t_free;
        final_report;
    end
endmodule // line_trigger_exposure_control_bench
